// file: design/te_sync_gen.sv
/*
  Frame sync generator with gate scan: produces the host-facing frame
  sync line in vertical-only or vertical-plus-horizontal mode, and the
  one-hot gate drive of the panel scan.
  Assumes commands arrive as one-cycle pulses synchronous to clk and
  that configuration inputs are held stable by the command decoder.
*/
module te_sync_gen
  import te_sync_pkg::*;
#(
  parameter int unsigned VS_HIGH_MIN_CYCLES = te_sync_pkg::VS_HIGH_MIN_CYC,
  parameter int unsigned HS_HIGH_MAX_CYCLES = te_sync_pkg::HS_HIGH_MAX_CYC
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Sync line commands
  input  wire logic                   te_on_cmd,
  input  wire logic                   te_off_cmd,
  input  wire te_sync_pkg::te_mode_t  te_mode_sel,
  input  wire logic                   sleep_in,
  // Configuration
  input  wire logic [15:0]            line_select_delay,
  input  wire logic [3:0]             osc_trim,
  input  wire te_sync_pkg::gate_cfg_t gate_cfg,
  // Panel side
  output logic                        frame_sync_out,
  output logic [431:0]                gate_on_level,
  output logic [8:0]                  scan_row
);

  // ==========================================================
  // Constants sized to the counters
  localparam logic [CNT_W-1:0] VS_MIN = CNT_W'(VS_HIGH_MIN_CYCLES);
  localparam logic [CNT_W-1:0] HS_MAX = CNT_W'(HS_HIGH_MAX_CYCLES);

  typedef enum logic [1:0] {
    SYNC_DISABLED,
    SYNC_VBLANK,
    SYNC_VHBLANK
  } sync_state_t;

  // ==========================================================
  // Timing base
  logic      osc_tick;
  scan_pos_t pos;

  osc_tick_gen u_osc
  (
    .clk      (clk),
    .resetn   (resetn),
    .osc_trim (osc_trim),
    .osc_tick (osc_tick)
  );

  scan_timer u_scan
  (
    .clk      (clk),
    .resetn   (resetn),
    .osc_tick (osc_tick),
    .pos      (pos)
  );

  // ==========================================================
  // Gate index for a logical scan line
  // Interleaved mode drives even gates for the first half, then odd; reversed shift direction swaps that parity
  function automatic logic [8:0] gate_index(input logic [8:0] line,
                                            input logic       sm,
                                            input logic       gs);
    logic [8:0] g;
    logic [8:0] rel;
    rel = line - HALF_LINES;
    if (!sm)
      g = line;
    else if (line < HALF_LINES)
      g = {line[7:0], 1'b0};
    else
      g = {rel[7:0], 1'b1};
    if (gs)
      g = LAST_ROW - g;
    return g;
  endfunction

  // ==========================================================
  // Command state
  sync_state_t state_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= SYNC_DISABLED;
    end
    else
    begin
      case (state_q)
        SYNC_DISABLED,
        SYNC_VBLANK,
        SYNC_VHBLANK:
        begin
          // Off wins when both commands land together
          if (te_off_cmd)
            state_q <= SYNC_DISABLED;
          else if (te_on_cmd)
            state_q <= (te_mode_sel == TE_MODE_VHBLANK) ? SYNC_VHBLANK
                                                        : SYNC_VBLANK;
        end
        default:
        begin
          state_q <= SYNC_DISABLED;
        end
      endcase
    end
  end

  // ==========================================================
  // Raw blanking windows
  logic [8:0]  v_start;
  logic [8:0]  h_count;
  logic        v_raw;
  logic        h_raw;
  logic        mode2;

  assign mode2 = (state_q == SYNC_VHBLANK);

  always_comb
  begin
    v_start = ACTIVE_LINES;
    h_count = ACTIVE_LINES;
    // Zero starts after the last active line; in vertical-only mode N starts at line N-1, capped at the last frame line
    if (!mode2 && line_select_delay != 16'h0000)
    begin
      if (line_select_delay >= {7'h00, TOTAL_LINES})
        v_start = TOTAL_LINES - 9'h001;
      else
        v_start = line_select_delay[8:0] - 9'h001;
    end
    // Each step of the select value drops one horizontal pulse
    if (line_select_delay >= {7'h00, ACTIVE_LINES})
      h_count = 9'h000;
    else
      h_count = ACTIVE_LINES - line_select_delay[8:0];
    // Window uses the logical line, so scan order cannot skew it
    v_raw = (line_dist(pos.line, v_start) < VBLANK_LINES);
    h_raw = mode2 && (pos.line < h_count) && (pos.dot < HBLANK_DOTS);
  end

  // ==========================================================
  // Vertical pulse with least width
  // Stretching past the window trades a late fall for the host margin
  logic             vs_q;
  logic [CNT_W-1:0] vs_cnt_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vs_q     <= 1'b0;
      vs_cnt_q <= '0;
    end
    else if (v_raw || (vs_q && vs_cnt_q < VS_MIN))
    begin
      vs_q <= 1'b1;
      if (vs_cnt_q != {CNT_W{1'b1}})
        vs_cnt_q <= vs_cnt_q + 17'h00001;
    end
    else
    begin
      vs_q     <= 1'b0;
      vs_cnt_q <= '0;
    end
  end

  // ==========================================================
  // Horizontal pulse with longest width
  logic             hs_q;
  logic [CNT_W-1:0] hs_cnt_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_q     <= 1'b0;
      hs_cnt_q <= '0;
    end
    else if (h_raw)
    begin
      hs_q <= (hs_cnt_q < HS_MAX - 17'h00001);
      if (hs_cnt_q != {CNT_W{1'b1}})
        hs_cnt_q <= hs_cnt_q + 17'h00001;
    end
    else
    begin
      hs_q     <= 1'b0;
      hs_cnt_q <= '0;
    end
  end

  // ==========================================================
  // Output pin
  logic sync_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sync_q <= 1'b0;
    else if (state_q == SYNC_DISABLED)
      sync_q <= 1'b0;
    else if (sleep_in)
      sync_q <= 1'b0;
    else
      sync_q <= vs_q | (mode2 & hs_q);
  end

  assign frame_sync_out = sync_q;

  // ==========================================================
  // Gate drive and readout row
  logic [431:0] gate_q;
  logic [8:0]   row_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_q <= '0;
      row_q  <= '0;
    end
    else
    begin
      gate_q <= '0;
      if (pos.line < ACTIVE_LINES)
        gate_q[gate_index(pos.line, gate_cfg.gate_scan_mode,
                          gate_cfg.gate_shift_dir)] <= 1'b1;
      if (pos.line >= ACTIVE_LINES)
        row_q <= '0;
      else if (gate_cfg.scan_order)
        row_q <= LAST_ROW - pos.line;
      else
        row_q <= pos.line;
    end
  end

  assign gate_on_level = gate_q;
  assign scan_row      = row_q;

endmodule

// file: design/te_sync_pkg.sv
/*
  Constants, types and shared helpers for the frame sync generator.
  Assumes a single 125 MHz clock and an active-low asynchronous reset.
*/
package te_sync_pkg;

  // ==========================================================
  // Clock and oscillator
  localparam int unsigned CLK_FREQ_HZ     = 125_000_000;
  localparam int unsigned OSC_DEFAULT_KHZ = 3690;
  localparam int unsigned OSC_DIV_NOM     =
    (CLK_FREQ_HZ / 1000 + OSC_DEFAULT_KHZ / 2) / OSC_DEFAULT_KHZ;
  localparam int          DIV_W           = 8;
  localparam logic [3:0]  OSC_TRIM_RESET  = 4'h8;

  // ==========================================================
  // Panel geometry
  localparam int          LINE_W         = 9;
  localparam int          DOT_W          = 7;
  localparam logic [8:0]  ACTIVE_LINES   = 9'h1b0;
  localparam logic [8:0]  VBLANK_LINES   = 9'h030;
  localparam logic [8:0]  TOTAL_LINES    = 9'h1e0;
  localparam logic [8:0]  LAST_ROW       = 9'h1af;
  localparam logic [8:0]  HALF_LINES     = 9'h0d8;
  localparam logic [6:0]  LAST_DOT       = 7'h7f;
  localparam logic [6:0]  HBLANK_DOTS    = 7'h10;
  localparam logic [15:0] TSEL_RESET     = 16'h0000;

  // ==========================================================
  // Sync pulse timing
  localparam int unsigned VS_HIGH_MIN_US  = 1000;
  localparam int unsigned HS_HIGH_MAX_US  = 500;
  localparam int unsigned VS_HIGH_MIN_CYC = VS_HIGH_MIN_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned HS_HIGH_MAX_CYC = HS_HIGH_MAX_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int          CNT_W           = 17;

  // ==========================================================
  // Types
  typedef enum logic {
    TE_MODE_VBLANK,
    TE_MODE_VHBLANK
  } te_mode_t;

  typedef struct packed {
    logic              gate_scan_mode;
    logic              gate_shift_dir;
    logic              scan_order;
  } gate_cfg_t;

  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic [DOT_W-1:0]  dot;
    logic              line_start;
  } scan_pos_t;

  // Distance of a line behind a start line, modulo the frame length
  function automatic logic [8:0] line_dist(input logic [8:0] line,
                                           input logic [8:0] start);
    logic [9:0] sum;
    sum = {1'b0, line} + {1'b0, TOTAL_LINES} - {1'b0, start};
    if (sum >= {1'b0, TOTAL_LINES})
      sum = sum - {1'b0, TOTAL_LINES};
    return sum[8:0];
  endfunction

endpackage

// file: design/osc_tick_gen.sv
/*
  Display clock enable: divides the system clock to the trimmed
  oscillator rate. Assumes the trim input is static or changes slowly.
*/
module osc_tick_gen
  import te_sync_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Trim
  input  wire logic [3:0] osc_trim,
  // Enable out
  output logic            osc_tick
);

  // ==========================================================
  // Divider
  // Higher trim gives a faster display clock
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] cnt_q;
  logic             tick_q;

  always_comb
  begin
    div_d = DIV_W'(OSC_DIV_NOM) + {4'h0, OSC_TRIM_RESET} - {4'h0, osc_trim};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= div_d - 8'h01)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign osc_tick = tick_q;

endmodule

// file: design/scan_timer.sv
/*
  Dot and line counters of the panel scan, advanced on the display
  clock enable. Assumes one enable pulse per dot.
*/
module scan_timer
  import te_sync_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // Dot enable
  input  wire logic      osc_tick,
  // Scan position
  output scan_pos_t      pos
);

  // ==========================================================
  // Counters
  scan_pos_t pos_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pos_q <= '0;
    end
    else
    begin
      pos_q.line_start <= 1'b0;
      if (osc_tick)
      begin
        if (pos_q.dot == LAST_DOT)
        begin
          pos_q.dot        <= '0;
          pos_q.line_start <= 1'b1;
          if (pos_q.line == TOTAL_LINES - 9'h001)
            pos_q.line <= '0;
          else
            pos_q.line <= pos_q.line + 9'h001;
        end
        else
        begin
          pos_q.dot <= pos_q.dot + 7'h01;
        end
      end
    end
  end

  assign pos = pos_q;

endmodule

// file: tb/te_sync_chk.sv
/* Port checker for te_sync_gen.
   Assumes the bind below and the bench's shortened pulse limits. */
module te_sync_chk
  import te_sync_pkg::*;
#(
  parameter int unsigned VS_HIGH_MIN_CYCLES = 200,
  parameter int unsigned HS_HIGH_MAX_CYCLES = 1000
)
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // Commands
  input wire logic                  te_on_cmd,
  input wire logic                  te_off_cmd,
  input wire te_sync_pkg::te_mode_t te_mode_sel,
  input wire logic                  sleep_in,
  // Outputs
  input wire logic                  frame_sync_out,
  input wire logic [431:0]          gate_on_level,
  input wire logic [8:0]            scan_row
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // Helpers: last mode, any enable yet, high run
  logic        m2_q;
  logic        seen_q;
  int unsigned hi_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      m2_q   <= 1'b0;
      seen_q <= 1'b0;
      hi_q   <= 0;
    end
    else
    begin
      if (te_on_cmd && !te_off_cmd)
      begin
        m2_q   <= (te_mode_sel == TE_MODE_VHBLANK);
        seen_q <= 1'b1;
      end
      hi_q <= frame_sync_out ? hi_q + 1 : 0;
    end
  end
  // ==========================================
  // Properties
  a_sleep_low: assert property (sleep_in |=> !frame_sync_out)
    else $error("sync high in sleep");
  a_off_low: assert property (te_off_cmd ##1 !te_on_cmd |=> !frame_sync_out)
    else $error("sync high after off");
  a_idle_low: assert property (!seen_q |-> !frame_sync_out)
    else $error("sync high before enable");
  a_gate_onehot: assert property ($onehot0(gate_on_level))
    else $error("two gates on");
  a_row_range: assert property (scan_row <= 9'h1af)
    else $error("row out of range");
  a_hs_max: assert property (m2_q && frame_sync_out && |gate_on_level
    |-> hi_q < HS_HIGH_MAX_CYCLES)
    else $error("horizontal pulse too long");
  a_hs_gap: assert property (m2_q && $fell(frame_sync_out) && |gate_on_level
    |-> !frame_sync_out [*8])
    else $error("horizontal low too short");
  a_vs_hold: assert property (!m2_q && $rose(frame_sync_out) && VS_HIGH_MIN_CYCLES > 8
    |=> frame_sync_out [*8])
    else $error("vertical pulse too short");
endmodule

bind te_sync_gen te_sync_chk #(
  .VS_HIGH_MIN_CYCLES(VS_HIGH_MIN_CYCLES),
  .HS_HIGH_MAX_CYCLES(HS_HIGH_MAX_CYCLES)
) i_te_sync_chk (.clk, .resetn, .te_on_cmd, .te_off_cmd, .te_mode_sel, .sleep_in,
  .frame_sync_out, .gate_on_level, .scan_row);

// file: tb/host_model.sv
/* Host side of the sync line: counts pulses and times them.
   Assumes the same clock and reset as the sync generator. */
module host_model (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  resetn,
  // Sync line
  input  wire logic  frame_sync_out,
  // Observations
  output int unsigned rises,
  output int unsigned last_hi,
  output logic       fast_wr,
  output logic       slow_go
);
  int unsigned run_q;
  logic        prev_q;
  // A fast host writes only while the sync line is high
  assign fast_wr = frame_sync_out;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rises   <= 0;
      last_hi <= 0;
      run_q   <= 0;
      prev_q  <= 1'b0;
      slow_go <= 1'b0;
    end
    else
    begin
      prev_q <= frame_sync_out;
      run_q  <= frame_sync_out ? run_q + 1 : 0;
      if (frame_sync_out && !prev_q)
        rises <= rises + 1;
      if (!frame_sync_out && prev_q)
      begin
        last_hi <= run_q;
        // Slow host starts only once a pulse has ended
        slow_go <= 1'b1;
      end
    end
  end
endmodule

// file: tb/te_sync_gen_tb.sv
/* Self-checking bench for te_sync_gen with a host model.
   Assumes trim at its reset value and shortened pulse limits. */
module te_sync_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import te_sync_pkg::*;
  localparam int unsigned LINE = (LAST_DOT + 1) * OSC_DIV_NOM;
  logic         clk = 0;
  logic         resetn = 0;
  logic         on = 0;
  logic         off = 0;
  logic         sleep = 0;
  te_mode_t     mode = TE_MODE_VBLANK;
  logic [15:0]  sel = 16'h0000;
  gate_cfg_t    cfg = '0;
  logic         fs;
  logic [431:0] gate;
  logic [8:0]   row;
  logic         slow_go;
  int unsigned  rises;
  int unsigned  last_hi;
  int           errors = 0;
  int           num_checks = 0;
  int           cyc = 0;

  te_sync_gen #(.VS_HIGH_MIN_CYCLES(200), .HS_HIGH_MAX_CYCLES(1000)) i_te_sync_gen (
    .clk(clk), .resetn(resetn), .te_on_cmd(on), .te_off_cmd(off), .te_mode_sel(mode),
    .sleep_in(sleep), .line_select_delay(sel), .osc_trim(OSC_TRIM_RESET), .gate_cfg(cfg),
    .frame_sync_out(fs), .gate_on_level(gate), .scan_row(row));
  host_model i_host_model (.clk(clk), .resetn(resetn), .frame_sync_out(fs), .rises(rises),
    .last_hi(last_hi), .fast_wr(), .slow_go(slow_go));

  always #4 clk = ~clk;
  // ==========================================
  // Timeout and checks
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors=%0d num_checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chkb(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  task automatic chkc(input int unsigned got, input int unsigned exp);
    num_checks++;
    if (got != exp)
    begin
      errors++;
      $display("ERROR %0t count got %0d want %0d", $time, got, exp);
    end
  endtask
  // ==========================================
  // Command and run tasks
  task automatic cmd(input logic o, input te_mode_t m);
    @(posedge clk);
    #1;
    on = o;
    off = !o;
    mode = m;
    @(posedge clk);
    #1;
    on = 0;
    off = 0;
  endtask
  // Reset, enable, then stop half a line short of n lines so edges never race
  task automatic run(input te_mode_t m, input logic [15:0] s, input gate_cfg_t c,
                     input int unsigned n);
    #1;
    resetn = 0;
    sel = s;
    cfg = c;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1;
    cmd(1, m);
    repeat ((2 * n - 1) * LINE / 2) @(posedge clk);
    #1;
  endtask

  initial
  begin
    run(TE_MODE_VHBLANK, 16'h0000, 3'b000, 4);
    chkc(rises, 4);
    chkc(last_hi, HBLANK_DOTS * OSC_DIV_NOM);
    chkb(slow_go, 1'b1);
    chkb(gate[3], 1'b1);
    chkc(row, 3);
    run(TE_MODE_VHBLANK, 16'h01ae, 3'b111, 4);
    chkc(rises, 2);
    chkc(last_hi, HBLANK_DOTS * OSC_DIV_NOM);
    chkb(gate[425], 1'b1);
    chkc(row, 428);
    run(TE_MODE_VBLANK, 16'h0000, 3'b000, 3);
    chkc(rises, 0);
    run(TE_MODE_VBLANK, 16'h0002, 3'b000, 3);
    chkc(rises, 1);
    chkb(fs, 1'b1);
    sleep = 1;
    repeat (2) @(posedge clk);
    #1;
    chkb(fs, 1'b0);
    sleep = 0;
    repeat (20) @(posedge clk);
    #1;
    chkb(fs, 1'b1);
    cmd(0, TE_MODE_VBLANK);
    repeat (2) @(posedge clk);
    #1;
    chkb(fs, 1'b0);
    cmd(1, TE_MODE_VHBLANK);
    repeat (4) @(posedge clk);
    #1;
    chkb(fs, 1'b0);
    finish_test();
  end
endmodule
